// >>> rtl/port_function_multiplexer.sv
// Pin function multiplexer for port A pins 16..30 and port B pins 0..23
// Notes on behaviour
// - Port A pin 16: GPIO 16; sync serial TXD, SPI1 MOSI, bus address 21.
// - Port A pin 17: GPIO 17; sync serial RXD, SPI1 MISO, bus address 22.
// - Port A pin 18: GPIO 18; sync serial RX clock, SPI1 CS1, MAC wake.
// - Port A pin 19: GPIO 19; sync serial RX frame sync, SPI1 CS2, slot C unused.
// - Port A pin 20: GPIO 20; external irq 8, SPI1 CS3, slot C unused.
// - Port A pins 21-24: ADC 0-3, irq 0-3, then sense, VBUS, DAC D1, D1 inverted.
// - Port A pins 25-28: ADC 4-7, keypad scan 0-3, bus CS0, address 20-22.
// - Port A pins 29, 30: two-wire SDA/SCL, USART2 RTS/CTS, slot C unused.
// - Port A pin n is GPIO line n; pin 30 is line 30.
// - Port B pin n is GPIO line 32 plus n.
// - Port B pins 0, 1: MAC TX clock/enable, USART2 then USART3 RTS/CTS.
// - Port B pins 2,3,5,6: MAC TXD0/1, RXD0/1; DAC D0, D0 inv, D1, D1 inv.
// - Port B pin 4: GPIO 36; MAC CRS, USART3 clock, bus CS3.
// - Port B pins 7,8,9,15 offer GPIO and only MAC RX error, MDC, MDIO, RX valid.
// - Port B pins 10, 11: MAC TXD2/3, USART3 RXD/TXD, SDRAM clock/enable.
// - Port B pins 12-14: MAC TXER/RXD2/RXD3, timer clocks 0-2, SDRAM strobes.
// - Port B pins 16, 17: MAC COL/RX clock, sense/VBUS, SDRAM A10/address 23.
// - Port B pin 18: GPIO 50; MAC speed, ADC trigger, PWM 6.
// - Port B pins 19-22: PWM 0-3, generic clocks 0-3, keypad scan 4-7.
// - Port B pin 23: GPIO 55; timer A0, USART1 DCD, slot C unused.
// - No open-drain mode; pad enable follows the selected source only.
`include "port_function_multiplexer_map.svh"
`default_nettype none

module port_function_multiplexer (
	input  wire logic                                              mclk,
	input  wire logic                                              rst_n,
	input  wire port_function_multiplexer_pkg::sel_type [`PMX_PIN_COUNT-1:0] pinSel,
	input  wire logic [`PMX_PIN_COUNT-1:0]                         padIn,
	output logic      [`PMX_PIN_COUNT-1:0]                         padOut,
	output logic      [`PMX_PIN_COUNT-1:0]                         padOe,
	input  wire logic [`PMX_GPIO_LINES-1:0]                        gpioOut,
	input  wire logic [`PMX_GPIO_LINES-1:0]                        gpioOe,
	output logic      [`PMX_GPIO_LINES-1:0]                        gpioIn,
	input  wire logic [`PMX_FN_COUNT-1:0]                          fnOut,
	input  wire logic [`PMX_FN_COUNT-1:0]                          fnOe,
	output logic      [`PMX_FN_COUNT-1:0]                          fnIn
);

	localparam int PINS  = `PMX_PIN_COUNT;
	localparam int FNS   = `PMX_FN_COUNT;
	localparam int LINES = `PMX_GPIO_LINES;

	typedef port_function_multiplexer_pkg::fn_type fn_type;

	// Slots A, B, C per pin, lowest index is port A pin 16
	localparam fn_type PIN_FUNCS [PINS][`PMX_SLOTS] = '{
		'{port_function_multiplexer_pkg::FN_SYNC_TXD,   port_function_multiplexer_pkg::FN_SPI1_MOSI,
		  port_function_multiplexer_pkg::FN_XBUS_A21},
		'{port_function_multiplexer_pkg::FN_SYNC_RXD,   port_function_multiplexer_pkg::FN_SPI1_MISO,
		  port_function_multiplexer_pkg::FN_XBUS_A22},
		'{port_function_multiplexer_pkg::FN_SYNC_RXCLK, port_function_multiplexer_pkg::FN_SPI1_CS1,
		  port_function_multiplexer_pkg::FN_MAC_WAKE},
		'{port_function_multiplexer_pkg::FN_SYNC_RXFS,  port_function_multiplexer_pkg::FN_SPI1_CS2,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_XIRQ8,      port_function_multiplexer_pkg::FN_SPI1_CS3,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_ADC0,       port_function_multiplexer_pkg::FN_XIRQ0,
		  port_function_multiplexer_pkg::FN_SENSE_A},
		'{port_function_multiplexer_pkg::FN_ADC1,       port_function_multiplexer_pkg::FN_XIRQ1,
		  port_function_multiplexer_pkg::FN_VBUS_SW},
		'{port_function_multiplexer_pkg::FN_ADC2,       port_function_multiplexer_pkg::FN_XIRQ2,
		  port_function_multiplexer_pkg::FN_DAC_D1},
		'{port_function_multiplexer_pkg::FN_ADC3,       port_function_multiplexer_pkg::FN_XIRQ3,
		  port_function_multiplexer_pkg::FN_DAC_DINV1},
		'{port_function_multiplexer_pkg::FN_ADC4,       port_function_multiplexer_pkg::FN_KSCAN0,
		  port_function_multiplexer_pkg::FN_XBUS_CS0},
		'{port_function_multiplexer_pkg::FN_ADC5,       port_function_multiplexer_pkg::FN_KSCAN1,
		  port_function_multiplexer_pkg::FN_XBUS_A20},
		'{port_function_multiplexer_pkg::FN_ADC6,       port_function_multiplexer_pkg::FN_KSCAN2,
		  port_function_multiplexer_pkg::FN_XBUS_A21},
		'{port_function_multiplexer_pkg::FN_ADC7,       port_function_multiplexer_pkg::FN_KSCAN3,
		  port_function_multiplexer_pkg::FN_XBUS_A22},
		'{port_function_multiplexer_pkg::FN_WIRE_SDA,   port_function_multiplexer_pkg::FN_U2_RTS,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_WIRE_SCL,   port_function_multiplexer_pkg::FN_U2_CTS,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_TXCLK,  port_function_multiplexer_pkg::FN_U2_RTS,
		  port_function_multiplexer_pkg::FN_U3_RTS},
		'{port_function_multiplexer_pkg::FN_MAC_TXEN,   port_function_multiplexer_pkg::FN_U2_CTS,
		  port_function_multiplexer_pkg::FN_U3_CTS},
		'{port_function_multiplexer_pkg::FN_MAC_TXD0,   port_function_multiplexer_pkg::FN_DAC_D0,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_TXD1,   port_function_multiplexer_pkg::FN_DAC_DINV0,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_CRS,    port_function_multiplexer_pkg::FN_U3_CLK,
		  port_function_multiplexer_pkg::FN_XBUS_CS3},
		'{port_function_multiplexer_pkg::FN_MAC_RXD0,   port_function_multiplexer_pkg::FN_DAC_D1,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_RXD1,   port_function_multiplexer_pkg::FN_DAC_DINV1,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_RXER,   port_function_multiplexer_pkg::FN_NONE,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_MDC,    port_function_multiplexer_pkg::FN_NONE,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_MDIO,   port_function_multiplexer_pkg::FN_NONE,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_TXD2,   port_function_multiplexer_pkg::FN_U3_RXD,
		  port_function_multiplexer_pkg::FN_SDR_CLK},
		'{port_function_multiplexer_pkg::FN_MAC_TXD3,   port_function_multiplexer_pkg::FN_U3_TXD,
		  port_function_multiplexer_pkg::FN_SDR_CKE},
		'{port_function_multiplexer_pkg::FN_MAC_TXER,   port_function_multiplexer_pkg::FN_TMR_CLK0,
		  port_function_multiplexer_pkg::FN_SDR_RAS},
		'{port_function_multiplexer_pkg::FN_MAC_RXD2,   port_function_multiplexer_pkg::FN_TMR_CLK1,
		  port_function_multiplexer_pkg::FN_SDR_CAS},
		'{port_function_multiplexer_pkg::FN_MAC_RXD3,   port_function_multiplexer_pkg::FN_TMR_CLK2,
		  port_function_multiplexer_pkg::FN_SDR_WE},
		'{port_function_multiplexer_pkg::FN_MAC_RXDV,   port_function_multiplexer_pkg::FN_NONE,
		  port_function_multiplexer_pkg::FN_NONE},
		'{port_function_multiplexer_pkg::FN_MAC_COL,    port_function_multiplexer_pkg::FN_SENSE_A,
		  port_function_multiplexer_pkg::FN_SDR_A10},
		'{port_function_multiplexer_pkg::FN_MAC_RXCLK,  port_function_multiplexer_pkg::FN_VBUS_SW,
		  port_function_multiplexer_pkg::FN_XBUS_A23},
		'{port_function_multiplexer_pkg::FN_MAC_SPEED,  port_function_multiplexer_pkg::FN_ADC_TRIG,
		  port_function_multiplexer_pkg::FN_PWM6},
		'{port_function_multiplexer_pkg::FN_PWM0,       port_function_multiplexer_pkg::FN_GENCLK0,
		  port_function_multiplexer_pkg::FN_KSCAN4},
		'{port_function_multiplexer_pkg::FN_PWM1,       port_function_multiplexer_pkg::FN_GENCLK1,
		  port_function_multiplexer_pkg::FN_KSCAN5},
		'{port_function_multiplexer_pkg::FN_PWM2,       port_function_multiplexer_pkg::FN_GENCLK2,
		  port_function_multiplexer_pkg::FN_KSCAN6},
		'{port_function_multiplexer_pkg::FN_PWM3,       port_function_multiplexer_pkg::FN_GENCLK3,
		  port_function_multiplexer_pkg::FN_KSCAN7},
		'{port_function_multiplexer_pkg::FN_TMR_A0,     port_function_multiplexer_pkg::FN_U1_DCD,
		  port_function_multiplexer_pkg::FN_NONE}
	};

	// Active-low functions idle high so a parked input cannot assert them
	function automatic logic fnIdle(input int id);
		case (id)
			int'(port_function_multiplexer_pkg::FN_SPI1_CS1),
			int'(port_function_multiplexer_pkg::FN_SPI1_CS2),
			int'(port_function_multiplexer_pkg::FN_SPI1_CS3),
			int'(port_function_multiplexer_pkg::FN_XBUS_CS0),
			int'(port_function_multiplexer_pkg::FN_XBUS_CS3),
			int'(port_function_multiplexer_pkg::FN_U2_RTS),
			int'(port_function_multiplexer_pkg::FN_U2_CTS),
			int'(port_function_multiplexer_pkg::FN_U3_RTS),
			int'(port_function_multiplexer_pkg::FN_U3_CTS),
			int'(port_function_multiplexer_pkg::FN_U1_DCD),
			int'(port_function_multiplexer_pkg::FN_SDR_RAS),
			int'(port_function_multiplexer_pkg::FN_SDR_CAS),
			int'(port_function_multiplexer_pkg::FN_SDR_WE): fnIdle = 1'b1;
			default: fnIdle = 1'b0;
		endcase
	endfunction : fnIdle

	function automatic logic [FNS-1:0] idleVector();
		logic [FNS-1:0] v;
		v = '0;
		for (int i = 0; i < FNS; i++) begin
			v[i] = fnIdle(i);
		end
		return v;
	endfunction : idleVector

	localparam logic [FNS-1:0] FN_IDLE = idleVector();

	// GPIO line of a pin index
	function automatic logic [5:0] gpioLine(input int p);
		if (p < `PMX_PORTA_PINS) begin
			gpioLine = 6'(`PMX_PORTA_FIRST + p);
		end else begin
			gpioLine = 6'(`PMX_PORTB_BASE + p - `PMX_PORTA_PINS);
		end
	endfunction : gpioLine

	function automatic fn_type slotFn(input int p, input port_function_multiplexer_pkg::sel_type s);
		case (s)
			port_function_multiplexer_pkg::SEL_A: slotFn = PIN_FUNCS[p][0];
			port_function_multiplexer_pkg::SEL_B: slotFn = PIN_FUNCS[p][1];
			port_function_multiplexer_pkg::SEL_C: slotFn = PIN_FUNCS[p][2];
			default: slotFn = port_function_multiplexer_pkg::FN_NONE;
		endcase
	endfunction : slotFn

	port_function_multiplexer_pkg::mux_state_type st_q;
	port_function_multiplexer_pkg::mux_state_type st_d;

	always_comb begin
		fn_type     id;
		logic [5:0] line;
		id = port_function_multiplexer_pkg::FN_NONE;
		line = 6'h00;
		st_d = st_q;
		st_d.sync1 = padIn;
		st_d.sync2 = st_q.sync1;
		st_d.fnIn = FN_IDLE;
		st_d.gpioIn = '0;
		if (st_q.warm != 2'h3) begin
			st_d.warm = st_q.warm + 2'h1;
		end
		// Descending walk: lowest pin wins when two pins pick one function
		for (int p = PINS - 1; p >= 0; p--) begin
			line = gpioLine(p);
			id = slotFn(p, pinSel[p]);
			st_d.gpioIn[line] = st_q.sync2[p];
			if (pinSel[p] == port_function_multiplexer_pkg::SEL_GPIO) begin
				st_d.padOut[p] = gpioOut[line];
				st_d.padOe[p] = gpioOe[line];
			end else if (id == port_function_multiplexer_pkg::FN_NONE) begin
				st_d.padOut[p] = `PMX_PAD_RESET;
				st_d.padOe[p] = 1'b0;
			end else begin
				st_d.padOut[p] = fnOut[id];
				st_d.padOe[p] = fnOe[id];
				st_d.fnIn[id] = st_q.sync2[p];
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q.sync1 <= {PINS{`PMX_SYNC_RESET}};
			st_q.sync2 <= {PINS{`PMX_SYNC_RESET}};
			st_q.padOut <= {PINS{`PMX_PAD_RESET}};
			st_q.padOe <= {PINS{1'b0}};
			st_q.fnIn <= FN_IDLE;
			st_q.gpioIn <= {LINES{`PMX_GPIO_IN_RESET}};
			st_q.warm <= 2'h0;
		end else begin
			st_q <= st_d;
		end
	end

	assign padOut = st_q.padOut;
	assign padOe = st_q.padOe;
	assign fnIn = st_q.fnIn;
	assign gpioIn = st_q.gpioIn;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	logic warmed;
	assign warmed = (st_q.warm == 2'h3);

	a_pin16_mosi_out: assert property ((pinSel[0] == port_function_multiplexer_pkg::SEL_B)
		|=> padOut[0] == $past(fnOut[port_function_multiplexer_pkg::FN_SPI1_MOSI]))
		else $error("port A pin 16 does not carry SPI1 MOSI");
	a_pa17_addr_oe: assert property ((pinSel[1] == port_function_multiplexer_pkg::SEL_C)
		|=> padOe[1] == $past(fnOe[port_function_multiplexer_pkg::FN_XBUS_A22]))
		else $error("port A pin 17 enable not from bus address 22");
	a_pa18_wake_out: assert property ((pinSel[2] == port_function_multiplexer_pkg::SEL_C)
		|=> padOut[2] == $past(fnOut[port_function_multiplexer_pkg::FN_MAC_WAKE]))
		else $error("port A pin 18 does not carry MAC wake");
	a_pa19_slot_empty: assert property ((pinSel[3] == port_function_multiplexer_pkg::SEL_C)
		|=> !padOe[3] && !padOut[3])
		else $error("unused slot on port A pin 19 drives the pad");
	a_pa20_irq_in: assert property (warmed && $stable(pinSel[4])
		&& pinSel[4] == port_function_multiplexer_pkg::SEL_A
		|=> fnIn[port_function_multiplexer_pkg::FN_XIRQ8] == $past(padIn[4], 3))
		else $error("irq 8 input not fed from port A pin 20");
	a_pa30_gpio_line: assert property ((pinSel[14] == port_function_multiplexer_pkg::SEL_GPIO)
		|=> padOut[14] == $past(gpioOut[30]) && padOe[14] == $past(gpioOe[30]))
		else $error("port A pin 30 not on GPIO line 30");
	a_pb01_gpio_line: assert property ((pinSel[16] == port_function_multiplexer_pkg::SEL_GPIO)
		|=> padOut[16] == $past(gpioOut[33]))
		else $error("port B pin 1 not on GPIO line 33");
	a_pb04_cs3_out: assert property ((pinSel[19] == port_function_multiplexer_pkg::SEL_C)
		|=> padOut[19] == $past(fnOut[port_function_multiplexer_pkg::FN_XBUS_CS3]))
		else $error("port B pin 4 does not carry bus CS3");
	a_pb18_pwm_out: assert property ((pinSel[33] == port_function_multiplexer_pkg::SEL_C)
		|=> padOut[33] == $past(fnOut[port_function_multiplexer_pkg::FN_PWM6]))
		else $error("port B pin 18 does not carry PWM 6");
	a_pb23_slot_empty: assert property ((pinSel[38] == port_function_multiplexer_pkg::SEL_C)
		|=> !padOe[38])
		else $error("unused slot on port B pin 23 drives the pad");
	a_cs1_idle_level: assert property ((pinSel[2] != port_function_multiplexer_pkg::SEL_B)
		|=> fnIn[port_function_multiplexer_pkg::FN_SPI1_CS1])
		else $error("parked SPI1 CS1 input not idle high");
	a_gpio_pin_in: assert property (warmed |-> gpioIn[36] == $past(padIn[19], 3))
		else $error("GPIO line 36 input not from port B pin 4");

	c_mosi_routed: cover property (pinSel[0] == port_function_multiplexer_pkg::SEL_B ##1 padOut[0]);
	c_pwm6_routed: cover property (pinSel[33] == port_function_multiplexer_pkg::SEL_C ##1 padOe[33]);
	c_empty_slot: cover property (pinSel[3] == port_function_multiplexer_pkg::SEL_C);
	c_gpio_drive: cover property (pinSel[16] == port_function_multiplexer_pkg::SEL_GPIO ##1 padOe[16]);

endmodule : port_function_multiplexer

`default_nettype wire

// >>> rtl/port_function_multiplexer_map.svh
// Sizes, line numbering and reset values of the port function multiplexer
`ifndef PORT_FUNCTION_MULTIPLEXER_MAP_SVH
`define PORT_FUNCTION_MULTIPLEXER_MAP_SVH

// Port A pins 16..30 come first, then port B pins 0..23
`define PMX_PORTA_FIRST   16
`define PMX_PORTA_PINS    15
`define PMX_PORTB_PINS    24
`define PMX_PIN_COUNT     39
`define PMX_PORTB_BASE    32
`define PMX_GPIO_LINES    56
`define PMX_FN_COUNT      93
`define PMX_SLOTS         3

// Reset values
`define PMX_PAD_RESET     1'b0
`define PMX_SYNC_RESET    1'b0
`define PMX_GPIO_IN_RESET 1'b0

// Input path latency, pin to registered function input
`define PMX_IN_LATENCY    3

`endif

// >>> rtl/port_function_multiplexer_pkg.sv
// Types shared by the port function multiplexer
`include "port_function_multiplexer_map.svh"
`default_nettype none

package port_function_multiplexer_pkg;

	// Per pin function select, Gray ordered along GPIO, A, B, C
	typedef enum logic [1:0] {
		SEL_GPIO = 2'h0,
		SEL_A    = 2'h1,
		SEL_B    = 2'h3,
		SEL_C    = 2'h2
	} sel_type;

	// Peripheral signal identifiers; FN_NONE marks an unused slot
	typedef enum logic [6:0] {
		FN_NONE = 7'h00,
		FN_SYNC_TXD, FN_SYNC_RXD, FN_SYNC_RXCLK, FN_SYNC_RXFS,
		FN_SPI1_MOSI, FN_SPI1_MISO, FN_SPI1_CS1, FN_SPI1_CS2, FN_SPI1_CS3,
		FN_XBUS_A20, FN_XBUS_A21, FN_XBUS_A22, FN_XBUS_A23, FN_XBUS_CS0, FN_XBUS_CS3,
		FN_MAC_WAKE,
		FN_XIRQ0, FN_XIRQ1, FN_XIRQ2, FN_XIRQ3, FN_XIRQ8,
		FN_KSCAN0, FN_KSCAN1, FN_KSCAN2, FN_KSCAN3,
		FN_KSCAN4, FN_KSCAN5, FN_KSCAN6, FN_KSCAN7,
		FN_ADC0, FN_ADC1, FN_ADC2, FN_ADC3, FN_ADC4, FN_ADC5, FN_ADC6, FN_ADC7,
		FN_ADC_TRIG, FN_SENSE_A, FN_VBUS_SW,
		FN_DAC_D0, FN_DAC_DINV0, FN_DAC_D1, FN_DAC_DINV1,
		FN_WIRE_SDA, FN_WIRE_SCL,
		FN_U2_RTS, FN_U2_CTS, FN_U3_RTS, FN_U3_CTS, FN_U3_CLK, FN_U3_RXD, FN_U3_TXD,
		FN_U1_DCD,
		FN_MAC_TXCLK, FN_MAC_TXEN, FN_MAC_TXD0, FN_MAC_TXD1, FN_MAC_TXD2, FN_MAC_TXD3,
		FN_MAC_TXER, FN_MAC_CRS, FN_MAC_RXD0, FN_MAC_RXD1, FN_MAC_RXD2, FN_MAC_RXD3,
		FN_MAC_RXER, FN_MAC_RXDV, FN_MAC_COL, FN_MAC_RXCLK, FN_MAC_MDC, FN_MAC_MDIO,
		FN_MAC_SPEED,
		FN_SDR_CLK, FN_SDR_CKE, FN_SDR_RAS, FN_SDR_CAS, FN_SDR_WE, FN_SDR_A10,
		FN_TMR_CLK0, FN_TMR_CLK1, FN_TMR_CLK2, FN_TMR_A0,
		FN_PWM0, FN_PWM1, FN_PWM2, FN_PWM3, FN_PWM6,
		FN_GENCLK0, FN_GENCLK1, FN_GENCLK2, FN_GENCLK3
	} fn_type;

	// Whole state of the multiplexer
	typedef struct packed {
		logic [`PMX_PIN_COUNT-1:0]  sync1;
		logic [`PMX_PIN_COUNT-1:0]  sync2;
		logic [`PMX_PIN_COUNT-1:0]  padOut;
		logic [`PMX_PIN_COUNT-1:0]  padOe;
		logic [`PMX_FN_COUNT-1:0]   fnIn;
		logic [`PMX_GPIO_LINES-1:0] gpioIn;
		logic [1:0]                 warm;
	} mux_state_type;

endpackage : port_function_multiplexer_pkg

`default_nettype wire

// >>> test/peripheral_side_model.sv
// Peripheral and GPIO controller side model: one source drives the wanted value, the others its inverse
`include "port_function_multiplexer_map.svh"
`default_nettype none

module peripheral_side_model (
	input  wire logic                       useGpio,
	input  wire logic [6:0]                 drvFn,
	input  wire logic [5:0]                 drvLine,
	input  wire logic                       drvVal,
	output logic      [`PMX_GPIO_LINES-1:0] gpioOut,
	output logic      [`PMX_GPIO_LINES-1:0] gpioOe,
	output logic      [`PMX_FN_COUNT-1:0]   fnOut,
	output logic      [`PMX_FN_COUNT-1:0]   fnOe
);
	timeunit 1ns;
	timeprecision 1ns;
	// Other sources show the inverse value and drop their enable while the value is high,
	// so a pad that listens to the wrong source shows a wrong value or enable
	always_comb begin
		gpioOut = {`PMX_GPIO_LINES{~drvVal}};
		gpioOe = {`PMX_GPIO_LINES{~drvVal}};
		fnOut = {`PMX_FN_COUNT{~drvVal}};
		fnOe = {`PMX_FN_COUNT{~drvVal}};
		if (useGpio) begin
			gpioOut[drvLine] = drvVal;
			gpioOe[drvLine] = 1'b1;
		end else begin
			fnOut[drvFn] = drvVal;
			fnOe[drvFn] = 1'b1;
		end
	end
endmodule : peripheral_side_model

`default_nettype wire

// >>> test/port_function_multiplexer_tb.sv
// Self-checking bench of the port function multiplexer
`include "port_function_multiplexer_map.svh"
`default_nettype none
`define PK port_function_multiplexer_pkg::

module port_function_multiplexer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {int pin; `PK sel_type sel; `PK fn_type fn;} row_type;
	logic                                    mclk = 1'b0;
	logic                                    rst_n = 1'b0;
	`PK sel_type [`PMX_PIN_COUNT-1:0]        pinSel;
	logic [`PMX_PIN_COUNT-1:0]               padIn, padOut, padOe;
	logic [`PMX_GPIO_LINES-1:0]              gpioOut, gpioOe, gpioIn;
	logic [`PMX_FN_COUNT-1:0]                fnOut, fnOe, fnIn;
	logic                                    useGpio, drvVal;
	logic [6:0]                              drvFn;
	logic [5:0]                              drvLine;
	int                                      n_errors = 0;
	int                                      total_checks = 0;
	int                                      line, p;
	row_type rows [26] = '{
		'{0, `PK SEL_A, `PK FN_SYNC_TXD}, '{0, `PK SEL_C, `PK FN_XBUS_A21},
		'{0, `PK SEL_B, `PK FN_SPI1_MOSI}, '{1, `PK SEL_C, `PK FN_XBUS_A22},
		'{1, `PK SEL_B, `PK FN_SPI1_MISO}, '{2, `PK SEL_C, `PK FN_MAC_WAKE},
		'{3, `PK SEL_B, `PK FN_SPI1_CS2}, '{4, `PK SEL_A, `PK FN_XIRQ8},
		'{5, `PK SEL_C, `PK FN_SENSE_A}, '{8, `PK SEL_C, `PK FN_DAC_DINV1},
		'{9, `PK SEL_B, `PK FN_KSCAN0}, '{12, `PK SEL_C, `PK FN_XBUS_A22},
		'{14, `PK SEL_B, `PK FN_U2_CTS}, '{15, `PK SEL_C, `PK FN_U3_RTS},
		'{17, `PK SEL_B, `PK FN_DAC_D0}, '{19, `PK SEL_C, `PK FN_XBUS_CS3},
		'{24, `PK SEL_A, `PK FN_MAC_MDIO}, '{26, `PK SEL_C, `PK FN_SDR_CKE},
		'{29, `PK SEL_C, `PK FN_SDR_WE}, '{32, `PK SEL_C, `PK FN_XBUS_A23},
		'{33, `PK SEL_C, `PK FN_PWM6}, '{37, `PK SEL_B, `PK FN_GENCLK3},
		'{38, `PK SEL_B, `PK FN_U1_DCD}, '{0, `PK SEL_GPIO, `PK FN_NONE},
		'{14, `PK SEL_GPIO, `PK FN_NONE}, '{16, `PK SEL_GPIO, `PK FN_NONE}};

	port_function_multiplexer u_port_function_multiplexer (.mclk(mclk), .rst_n(rst_n),
		.pinSel(pinSel), .padIn(padIn), .padOut(padOut), .padOe(padOe), .gpioOut(gpioOut),
		.gpioOe(gpioOe), .gpioIn(gpioIn), .fnOut(fnOut), .fnOe(fnOe), .fnIn(fnIn));
	peripheral_side_model u_peripheral_side_model (.useGpio(useGpio), .drvFn(drvFn),
		.drvLine(drvLine), .drvVal(drvVal), .gpioOut(gpioOut), .gpioOe(gpioOe),
		.fnOut(fnOut), .fnOe(fnOe));

	always #20 mclk = ~mclk;

	task automatic check(input logic got, input logic exp, input string what);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : check

	task automatic complete_run;
		$display("checks %0d, errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : complete_run

	// Whole run is some 220 cycles; far more means a hang
	initial begin
		repeat (5000) @(posedge mclk);
		n_errors++;
		complete_run();
	end

	initial begin
		foreach (pinSel[i]) pinSel[i] = `PK SEL_GPIO;
		padIn = '0;
		{useGpio, drvVal, drvFn, drvLine} = '0;
		repeat (7) @(posedge mclk);
		#1;
		check(|padOe, 1'b0, "enable in reset");
		check(fnIn[`PK FN_SPI1_CS1], 1'b1, "idle chip select in reset");
		@(posedge mclk);
		#1;
		rst_n = 1'b1;
		for (int r = 0; r < 26; r++) begin
			for (int v = 0; v < 2; v++) begin
				@(posedge mclk);
				#1;
				p = rows[r].pin;
				pinSel[p] = rows[r].sel;
				padIn[p] = v[0];
				line = p < `PMX_PORTA_PINS ? p + `PMX_PORTA_FIRST : p - `PMX_PORTA_PINS + `PMX_PORTB_BASE;
				useGpio = rows[r].sel == `PK SEL_GPIO;
				drvFn = rows[r].fn;
				drvLine = line[5:0];
				drvVal = v[0];
				@(posedge mclk);
				#1;
				check(padOut[p], v[0], "pad value from selected source");
				check(padOe[p], 1'b1, "pad enable");
				repeat (2) @(posedge mclk);
				#1;
				check(gpioIn[line], v[0], "gpio line number");
				if (rows[r].fn != `PK FN_NONE)
					check(fnIn[rows[r].fn], v[0], "function input");
			end
			pinSel[p] = `PK SEL_GPIO;
		end
		// Deselected active-low input must fall back to its idle high
		pinSel[2] = `PK SEL_B;
		padIn[2] = 1'b0;
		repeat (3) @(posedge mclk);
		#1;
		check(fnIn[`PK FN_SPI1_CS1], 1'b0, "chip select follows pad");
		pinSel[2] = `PK SEL_GPIO;
		@(posedge mclk);
		#1;
		check(fnIn[`PK FN_SPI1_CS1], 1'b1, "idle after deselect");
		// Unused slots while every source is driving
		useGpio = 1'b0;
		drvVal = 1'b0;
		pinSel[3] = `PK SEL_C;
		pinSel[38] = `PK SEL_C;
		@(posedge mclk);
		#1;
		check(padOe[3] | padOut[3], 1'b0, "unused slot on pin 19");
		check(padOe[38] | padOut[38], 1'b0, "unused slot on pin 23");
		pinSel[0] = `PK SEL_GPIO;
		rst_n = 1'b0;
		#1;
		check(padOe[0], 1'b0, "enable under mid-run reset");
		@(posedge mclk);
		#1;
		rst_n = 1'b1;
		@(posedge mclk);
		#1;
		check(padOut[0] & padOe[0], 1'b1, "pad loads on first edge after reset");
		complete_run();
	end
endmodule : port_function_multiplexer_tb

`undef PK
`default_nettype wire
